// file: verilog/fdfc_cfg.svh
// fdfc_cfg.svh: bit positions, codes and reset values of the feedback divider block
// How it works
// - prescaler-select bit picks small or large modulus
// - 13-bit main counter from word bits 19:7
// - 5-bit swallow counter from word bits 6:2
// - swallow value 0..31, plain binary ratio
// - timeout word layout zeros, select, count, address 10
// - count 0: fast-acquire off, pin released
// - count 1: pin low, pump forced 4X
// - count 2: pin low, pump follows magnitude
// - count 3: pin high, pump follows magnitude
// - count 4..4095: timed fast-acquire by events
// - timed: 4X until count reaches 0
// - magnitude bit picks 1X or 4X immediately for counts 0, 2 and 3
// - three select bits choose multi-function output
`ifndef FDFC_CFG_SVH
`define FDFC_CFG_SVH

// ----------------------------------------------------------------
// serial word layout
// ----------------------------------------------------------------
`define FDFC_WORD_W        22
`define FDFC_ADDR_HI       1
`define FDFC_ADDR_LO       0
`define FDFC_ADDR_REF      2'h0
`define FDFC_ADDR_DIV      2'h1
`define FDFC_ADDR_TMO      2'h2

// reference word fields used here
`define FDFC_R_SEL_MID     21
`define FDFC_R_SEL_LOW     20
`define FDFC_R_CUR_MAG     18

// divider word fields
`define FDFC_N_PRESCALE    20
`define FDFC_N_MAIN_HI     19
`define FDFC_N_MAIN_LO     7
`define FDFC_N_SWAL_HI     6
`define FDFC_N_SWAL_LO     2

// timeout word fields
`define FDFC_T_SEL_HIGH    14
`define FDFC_T_CNT_HI      13
`define FDFC_T_CNT_LO      2

// timeout count codes
`define FDFC_TMO_OFF       12'h000
`define FDFC_TMO_MANUAL    12'h001
`define FDFC_TMO_LOW       12'h002
`define FDFC_TMO_HIGH      12'h003

// prescaler small modulus per variant and select value
`define FDFC_P_LARGE_SEL0  6'h10
`define FDFC_P_LARGE_SEL1  6'h20
`define FDFC_P_SMALL_SEL0  6'h08
`define FDFC_P_SMALL_SEL1  6'h10

// reset values
`define FDFC_RST_MAIN      13'h0003
`define FDFC_RST_SWAL      5'h00
`define FDFC_RST_TMO       12'h000

`endif

// file: verilog/fdfc_pkg.sv
// fdfc_pkg.sv: types of the feedback divider and fast-acquire block
package fdfc_pkg;

  // fast-acquire operating mode taken from the timeout count
  typedef enum logic [2:0] {
    FDFC_FA_OFF,
    FDFC_FA_MANUAL,
    FDFC_FA_LOW,
    FDFC_FA_HIGH,
    FDFC_FA_TIMED
  } fdfc_fa_mode_e;

  // two-way style pin: level and drive enable
  typedef struct packed {
    logic out;
    logic oe;
  } fdfc_pin_s;

  // programmed divider setting
  typedef struct packed {
    logic        prescale_sel;
    logic [12:0] main_count_word;
    logic [4:0]  swallow_count_word;
  } fdfc_div_s;

endpackage

// file: verilog/fdfc_top.sv
// fdfc_top.sv: serial load, dual-modulus feedback counters and fast-acquire timeout
`include "fdfc_cfg.svh"

module fdfc_top
  import fdfc_pkg::*;
#(
  parameter bit SMALL_VARIANT = 1'b0
) (
  input  wire logic  clk,
  input  wire logic  rst_n,
  input  wire logic  ser_clk,
  input  wire logic  ser_data,
  input  wire logic  ser_latch,
  input  wire logic  pd_event,
  input  wire logic  prescaler_tick,
  output fdfc_div_s  div_setting_reg,
  output logic       modulus_high_reg,
  output logic       fb_pulse_reg,
  output logic       pump_current_boost_reg,
  output fdfc_pin_s  fast_acquire_pin_reg,
  output logic [2:0] out_select_reg,
  output logic [11:0] acquire_timeout_count_reg
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] sck_sync_reg;
  logic [1:0] sda_sync_reg;
  logic [1:0] sle_sync_reg;
  logic       sck_last_reg;
  logic       sle_last_reg;

  // two flops per pin, then edge history on the second for clock and latch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_sync_reg <= 2'h0;
      sda_sync_reg <= 2'h0;
      sle_sync_reg <= 2'h0;
      sck_last_reg <= 1'b0;
      sle_last_reg <= 1'b0;
    end else begin
      sck_sync_reg <= {sck_sync_reg[0], ser_clk};
      sda_sync_reg <= {sda_sync_reg[0], ser_data};
      sle_sync_reg <= {sle_sync_reg[0], ser_latch};
      sck_last_reg <= sck_sync_reg[1];
      sle_last_reg <= sle_sync_reg[1];
    end
  end

  wire sck_rise = sck_sync_reg[1] & ~sck_last_reg;
  wire sle_rise = sle_sync_reg[1] & ~sle_last_reg;

  // ----------------------------------------------------------------
  // serial shift register and word decode
  // ----------------------------------------------------------------
  logic [`FDFC_WORD_W-1:0] shift_reg;

  // msb first, one bit per serial clock rise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= '0;
    end else if (sck_rise) begin
      shift_reg <= {shift_reg[`FDFC_WORD_W-2:0], sda_sync_reg[1]};
    end
  end

  wire [1:0]  word_addr = shift_reg[`FDFC_ADDR_HI:`FDFC_ADDR_LO];
  wire        load_ref  = sle_rise & (word_addr == `FDFC_ADDR_REF);
  wire        load_div  = sle_rise & (word_addr == `FDFC_ADDR_DIV);
  wire        load_tmo  = sle_rise & (word_addr == `FDFC_ADDR_TMO);
  wire [11:0] tmo_field = shift_reg[`FDFC_T_CNT_HI:`FDFC_T_CNT_LO];

  // ----------------------------------------------------------------
  // control bits held from the reference and timeout words
  // ----------------------------------------------------------------
  logic cur_mag_reg;

  // magnitude bit plus the three output select bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_mag_reg    <= 1'b0;
      out_select_reg <= 3'h0;
    end else begin
      if (load_ref) begin
        cur_mag_reg       <= shift_reg[`FDFC_R_CUR_MAG];
        out_select_reg[1] <= shift_reg[`FDFC_R_SEL_MID];
        out_select_reg[0] <= shift_reg[`FDFC_R_SEL_LOW];
      end
      if (load_tmo) begin
        out_select_reg[2] <= shift_reg[`FDFC_T_SEL_HIGH];
      end
    end
  end

  // ----------------------------------------------------------------
  // divider setting
  // ----------------------------------------------------------------
  // fields copied straight, no range clamp: host keeps values legal
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_setting_reg <= '{1'b0, `FDFC_RST_MAIN, `FDFC_RST_SWAL};
    end else if (load_div) begin
      div_setting_reg.prescale_sel       <= shift_reg[`FDFC_N_PRESCALE];
      div_setting_reg.main_count_word    <= shift_reg[`FDFC_N_MAIN_HI:`FDFC_N_MAIN_LO];
      div_setting_reg.swallow_count_word <= shift_reg[`FDFC_N_SWAL_HI:`FDFC_N_SWAL_LO];
    end
  end

  // small modulus selected by variant and select bit, for reference
  wire [5:0] p_small = SMALL_VARIANT ?
                       (div_setting_reg.prescale_sel ? `FDFC_P_SMALL_SEL1 : `FDFC_P_SMALL_SEL0) :
                       (div_setting_reg.prescale_sel ? `FDFC_P_LARGE_SEL1 : `FDFC_P_LARGE_SEL0);

  // ----------------------------------------------------------------
  // dual-modulus counters
  // ----------------------------------------------------------------
  logic [12:0] main_feedback_count_reg;
  logic [4:0]  swallow_count_reg;

  wire cycle_end  = prescaler_tick & (main_feedback_count_reg <= 13'h0001);
  wire [12:0] main_next = cycle_end ? div_setting_reg.main_count_word
                        : main_feedback_count_reg - 13'h0001;
  wire [4:0]  swal_next = cycle_end ? div_setting_reg.swallow_count_word
                        : (swallow_count_reg != 5'h00 ? swallow_count_reg - 5'h01 : 5'h00);

  // high modulus for the swallow ticks, low for the rest: P*main + swallow
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      main_feedback_count_reg <= `FDFC_RST_MAIN;
      swallow_count_reg       <= `FDFC_RST_SWAL;
      modulus_high_reg        <= 1'b0;
      fb_pulse_reg            <= 1'b0;
    end else begin
      fb_pulse_reg     <= cycle_end;
      if (prescaler_tick) begin
        main_feedback_count_reg <= main_next;
        swallow_count_reg       <= swal_next;
        modulus_high_reg        <= (swal_next != 5'h00);
      end
    end
  end

  // ----------------------------------------------------------------
  // fast-acquire mode and timeout counter
  // ----------------------------------------------------------------
  fdfc_fa_mode_e fa_mode_reg;
  fdfc_fa_mode_e fa_mode_next;

  // decode of a freshly loaded timeout count
  always_comb begin
    case (tmo_field)
      `FDFC_TMO_OFF:    fa_mode_next = FDFC_FA_OFF;
      `FDFC_TMO_MANUAL: fa_mode_next = FDFC_FA_MANUAL;
      `FDFC_TMO_LOW:    fa_mode_next = FDFC_FA_LOW;
      `FDFC_TMO_HIGH:   fa_mode_next = FDFC_FA_HIGH;
      default:          fa_mode_next = FDFC_FA_TIMED;
    endcase
  end

  wire timed_run = (fa_mode_reg == FDFC_FA_TIMED) & (acquire_timeout_count_reg != 12'h000);

  // load on word, count down per event in timed mode, hold at zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fa_mode_reg               <= FDFC_FA_OFF;
      acquire_timeout_count_reg <= `FDFC_RST_TMO;
    end else if (load_tmo) begin
      fa_mode_reg               <= fa_mode_next;
      acquire_timeout_count_reg <= tmo_field;
    end else if (timed_run & pd_event) begin
      acquire_timeout_count_reg <= acquire_timeout_count_reg - 12'h001;
    end
  end

  // ----------------------------------------------------------------
  // pump current and fast-acquire pin
  // ----------------------------------------------------------------
  logic      boost_next;
  fdfc_pin_s pin_next;

  // pump level and pin drive for each fast-acquire mode
  always_comb begin
    case (fa_mode_reg)
      FDFC_FA_OFF: begin
        boost_next = cur_mag_reg;
        pin_next   = '{1'b0, 1'b0};
      end
      FDFC_FA_MANUAL: begin
        boost_next = 1'b1;
        pin_next   = '{1'b0, 1'b1};
      end
      FDFC_FA_LOW: begin
        boost_next = cur_mag_reg;
        pin_next   = '{1'b0, 1'b1};
      end
      FDFC_FA_HIGH: begin
        boost_next = cur_mag_reg;
        pin_next   = '{1'b1, 1'b1};
      end
      FDFC_FA_TIMED: begin
        boost_next = timed_run;
        pin_next   = '{1'b0, timed_run};
      end
      default: begin
        boost_next = cur_mag_reg;
        pin_next   = '{1'b0, 1'b0};
      end
    endcase
  end

  // one cycle after the held mode, count and magnitude, no further delay
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pump_current_boost_reg <= 1'b0;
      fast_acquire_pin_reg   <= '{1'b0, 1'b0};
    end else begin
      pump_current_boost_reg <= boost_next;
      fast_acquire_pin_reg   <= pin_next;
    end
  end

endmodule

// file: dv/fdfc_top_chk.sv
// fdfc_top_chk.sv: port assertions for the feedback divider and fast-acquire block
module fdfc_top_chk
  import fdfc_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        pd_event,
  input wire logic        prescaler_tick,
  input wire logic        fb_pulse_reg,
  input wire logic        pump_current_boost_reg,
  input wire fdfc_pin_s   fast_acquire_pin_reg,
  input wire logic [11:0] acquire_timeout_count_reg
);
  timeunit 1ns;
  timeprecision 1ns;
  // short views of the watched outputs
  wire [11:0] cnt   = acquire_timeout_count_reg;
  wire        boost = pump_current_boost_reg;
  wire        oe    = fast_acquire_pin_reg.oe;
  wire        pin   = fast_acquire_pin_reg.out;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // timeout count, pump current, fast-acquire pin and frame pulse
  // ----------------------------------------------------------------
  property p_dec; pd_event && cnt > 12'h003 |=> cnt == $past(cnt) - 12'h001; endproperty
  a_dec: assert property (p_dec) else $error("timeout count did not step down");
  property p_timed; cnt > 12'h003 |=> boost && oe && !pin; endproperty
  a_timed: assert property (p_timed) else $error("timed acquire not boosted");
  property p_end; $past(pd_event) && $past(cnt) == 12'h001 && cnt == 12'h000 |=> !boost && !oe; endproperty
  a_end: assert property (p_end) else $error("timeout end left boost on");
  property p_manual; cnt == 12'h001 |=> boost && oe && !pin; endproperty
  a_manual: assert property (p_manual) else $error("manual acquire wrong");
  property p_low; cnt == 12'h002 |=> oe && !pin; endproperty
  a_low: assert property (p_low) else $error("pin not driven low");
  property p_off; cnt == 12'h000 |=> !oe; endproperty
  a_off: assert property (p_off) else $error("pin not released");
  property p_fb_src; fb_pulse_reg |-> $past(prescaler_tick); endproperty
  a_fb_src: assert property (p_fb_src) else $error("frame end without tick");
  property p_fb_one; fb_pulse_reg |=> !fb_pulse_reg; endproperty
  a_fb_one: assert property (p_fb_one) else $error("frame pulse too long");
endmodule

bind fdfc_top fdfc_top_chk u_chk (
  .clk(clk), .rst_n(rst_n), .pd_event(pd_event), .prescaler_tick(prescaler_tick), .fb_pulse_reg(fb_pulse_reg),
  .pump_current_boost_reg(pump_current_boost_reg), .fast_acquire_pin_reg(fast_acquire_pin_reg),
  .acquire_timeout_count_reg(acquire_timeout_count_reg)
);

// file: dv/fdfc_host.sv
// fdfc_host.sv: serial loader model driving the three-wire control port
module fdfc_host (
  input  wire logic clk,
  output logic      ser_clk,
  output logic      ser_data,
  output logic      ser_latch
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // idle pins, then one word per call
  // ----------------------------------------------------------------
  initial begin
    ser_clk = 1'h0;
    ser_data = 1'h0;
    ser_latch = 1'h0;
  end
  // msb first, spd clocks per level, then latch pulse
  task automatic load(input logic [21:0] w, input int spd);
    for (int i = 21; i >= 0; i--) begin
      ser_data = w[i];
      repeat (spd) @(negedge clk);
      ser_clk = 1'h1;
      repeat (spd) @(negedge clk);
      ser_clk = 1'h0;
    end
    ser_data = ~w[0]; // data no longer valid
    repeat (spd) @(negedge clk);
    ser_latch = 1'h1;
    repeat (spd) @(negedge clk);
    ser_latch = 1'h0;
    repeat (spd) @(negedge clk);
  endtask
endmodule

// file: dv/fdfc_top_test.sv
// fdfc_top_test.sv: self-checking bench for the feedback divider block
module fdfc_top_test
  import fdfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk;
  logic        rst_n;
  logic        pd_event;
  logic        prescaler_tick;
  logic        tick_en;
  logic        ser_clk;
  logic        ser_data;
  logic        ser_latch;
  fdfc_div_s   div_setting_reg;
  logic        modulus_high_reg;
  logic        fb_pulse_reg;
  logic        boost;
  fdfc_pin_s   pin;
  logic [2:0]  out_select_reg;
  logic [11:0] tmo_cnt;
  logic [12:0] m;
  logic [4:0]  s;
  logic [11:0] c;
  logic [2:0]  sel;
  logic        mg;
  logic        p;
  int          mismatches;
  int          total_checks;
  int          seed;
  int          ticks;
  int          hi_ticks;
  logic [17:0] note_q[$];
  fdfc_host host (.clk(clk), .ser_clk(ser_clk), .ser_data(ser_data), .ser_latch(ser_latch));
  fdfc_top uut (.clk(clk), .rst_n(rst_n), .ser_clk(ser_clk), .ser_data(ser_data), .ser_latch(ser_latch),
    .pd_event(pd_event), .prescaler_tick(prescaler_tick), .div_setting_reg(div_setting_reg),
    .modulus_high_reg(modulus_high_reg), .fb_pulse_reg(fb_pulse_reg), .pump_current_boost_reg(boost),
    .fast_acquire_pin_reg(pin), .out_select_reg(out_select_reg), .acquire_timeout_count_reg(tmo_cnt));
  // ----------------------------------------------------------------
  // clock, ticks, frame watcher and helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  // random-gapped prescaler cycles
  always @(negedge clk) prescaler_tick <= tick_en && !prescaler_tick && $random(seed) % 3 == 0;
  // count ticks and high-modulus ticks per frame
  always @(posedge clk) begin
    if (fb_pulse_reg === 1'h1) begin
      if (note_q.size() > 0) chk({ticks[12:0], hi_ticks[4:0]}, note_q.pop_front());
      ticks = 0;
      hi_ticks = 0;
    end
    if (prescaler_tick === 1'h1) ticks++;
    if (prescaler_tick === 1'h1 && modulus_high_reg === 1'h1) hi_ticks++;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wait_fb;
    int n;
    n = 0;
    while (fb_pulse_reg !== 1'h1 && n <= 400) begin
      @(negedge clk);
      n++;
    end
    // a frame that never ends counts once and the run goes on to the report
    if (n > 400) mismatches++;
    @(negedge clk);
  endtask
  // main sequence
  initial begin
    seed = 49684;
    rst_n = 1'h0;
    pd_event = 1'h0;
    tick_en = 1'h0;
    repeat (12) @(negedge clk);
    rst_n = 1'h1;
    @(negedge clk);
    chk({div_setting_reg, pin.oe, boost, tmo_cnt}, {1'h0, 13'h0003, 5'h00, 14'h0000});
    for (int k = 0; k < 3; k++) begin
      p = k[0];
      m = (k == 0) ? 13'h0003 : 13'h0003 + 13'($unsigned($random(seed)) % 8);
      s = (k == 0) ? 5'h03 : 5'($unsigned($random(seed)) % (m + 13'h0001));
      host.load({1'h0, p, m, s, 2'h1}, 3 + k);
      repeat (8) @(negedge clk);
      chk(div_setting_reg, {p, m, s});
      tick_en = 1'h1;
      wait_fb();
      note_q.push_back({m, s});
      note_q.push_back({m, s});
      wait_fb();
      wait_fb();
      tick_en = 1'h0;
    end
    host.load({1'h0, 1'h1, 13'h1FFF, 5'h1F, 2'h3}, 3);
    repeat (8) @(negedge clk);
    chk(div_setting_reg, {p, m, s});
    chk(note_q.size(), 0);
    $display("divider test done");
    for (int t = 0; t < 4; t++) begin
      mg = 1'($random(seed));
      sel = 3'($random(seed));
      host.load({sel[1:0], 1'h0, mg, 1'h0, 15'h0002, 2'h0}, 3);
      host.load({7'h00, sel[2], 12'(t), 2'h2}, 4);
      repeat (8) @(negedge clk);
      chk({out_select_reg, tmo_cnt}, {sel, 12'(t)});
      chk({pin.oe, pin.oe & pin.out, boost}, {t != 0, t == 3, t == 1 || mg});
    end
    $display("mode test done");
    c = 12'h004 + 12'($unsigned($random(seed)) % 6);
    host.load({4'h1, 1'h0, 15'h0002, 2'h0}, 3);
    host.load({7'h00, 1'h0, c, 2'h2}, 3);
    repeat (8) @(negedge clk);
    for (int i = 0; i <= int'(c); i++) begin
      if (i < int'(c)) chk({tmo_cnt, pin.oe, pin.out, boost}, {c - 12'(i), 3'h5});
      pd_event = 1'h1;
      @(negedge clk);
      pd_event = 1'h0;
      repeat (2) @(negedge clk);
    end
    chk({tmo_cnt, pin.oe, boost}, 14'h0000);
    $display("timeout test done");
    tally_and_finish();
  end
endmodule
